// >>> rtl/msigen_defines.svh
// register map, field positions, reset values and codes of the
// message interrupt generator; included by its vector selector and top level
`ifndef MSIGEN_DEFINES_SVH
`define MSIGEN_DEFINES_SVH

// byte offsets, decoded on haddr[7:0]
`define MSIGEN_OFS_CONTROL    8'h80
`define MSIGEN_OFS_ADDR_LO    8'h84
`define MSIGEN_OFS_ADDR_HI    8'h88
`define MSIGEN_OFS_PAYLOAD    8'h8c
`define MSIGEN_OFS_PENDING    8'h94
`define MSIGEN_OFS_IRQ_STATUS 8'h98
`define MSIGEN_OFS_IRQ_MASK   8'h9c
`define MSIGEN_OFS_LAST_MSG   8'ha0

// control word fields
`define MSIGEN_ENABLE_BIT     16
`define MSIGEN_VCOUNT_LSB     20
`define MSIGEN_VCOUNT_MSB     22

// granted vector count codes; 3'h4 to 3'h7 are reserved
`define MSIGEN_VC_ONE         3'h0
`define MSIGEN_VC_TWO         3'h1
`define MSIGEN_VC_FOUR        3'h2
`define MSIGEN_VC_EIGHT       3'h3

// payload bits that each count leaves untouched
`define MSIGEN_KEEP_ONE       16'hffff
`define MSIGEN_KEEP_TWO       16'hfffe
`define MSIGEN_KEEP_FOUR      16'hfffc
`define MSIGEN_KEEP_EIGHT     16'hfff8

// interrupt status and mask bits
`define MSIGEN_IRQ_SENT_BIT   0
`define MSIGEN_IRQ_LOST_BIT   1

// reset values
`define MSIGEN_RST_WORD       32'h0000_0000
`define MSIGEN_RST_PAYLOAD    16'h0000
`define MSIGEN_RST_VCOUNT     3'h0

`endif

// >>> rtl/msigen_pkg.sv
// types of the message interrupt generator
// assumes the defines header is compiled alongside
package msigen_pkg;

  // one posted interrupt write towards the upstream port
  typedef struct packed {
    logic [63:0] addr;    // target, bits 1:0 always zero
    logic        wide64;  // high when a 64-bit address is used
    logic [15:0] data;    // payload with the vector merged in
    logic [2:0]  vector;  // source number that caused it
  } msigen_msg_t;

  // bus address phase held over into its data phase
  typedef struct packed {
    logic       valid;
    logic       write;
    logic [7:0] addr;
  } msigen_phase_t;

  // sender states, gray along idle -> send -> idle
  typedef enum logic [1:0] {
    MSIGEN_IDLE = 2'b00,
    MSIGEN_SEND = 2'b01
  } msigen_state_t;

endpackage

// >>> rtl/msigen_vector_sel.sv
// picks the next pending source and builds its payload
// assumes pending bits and settings come from the same clock
`timescale 1ns/10ps
`include "msigen_defines.svh"

module msigen_vector_sel (
  input  wire logic [7:0]  pending,  // one bit per source
  input  wire logic [2:0]  vcount,   // granted vector count code
  input  wire logic [15:0] payload,  // programmed message data
  output logic             found,    // some source is pending
  output logic [2:0]       source,   // chosen source number
  output logic [15:0]      data      // payload to transmit
);

  // lowest set bit wins; a busy low source can starve high ones
  function automatic logic [2:0] first_set(input logic [7:0] bits);
    logic [2:0] idx;
    idx = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (bits[i]) begin
        idx = 3'(i);
      end
    end
    return idx;
  endfunction

  // mask of payload bits the granted count leaves alone
  function automatic logic [15:0] keep_mask(input logic [2:0] code);
    logic [15:0] keep;
    keep = `MSIGEN_KEEP_ONE;
    case (code)
      `MSIGEN_VC_TWO:   keep = `MSIGEN_KEEP_TWO;   // [RULE_12]
      `MSIGEN_VC_FOUR:  keep = `MSIGEN_KEEP_FOUR;  // [RULE_11]
      `MSIGEN_VC_EIGHT: keep = `MSIGEN_KEEP_EIGHT; // [RULE_08]
      default:          keep = `MSIGEN_KEEP_ONE;   // [RULE_13]
    endcase
    return keep;
  endfunction

  wire [15:0] keep = keep_mask(vcount);                 // [RULE_10]
  wire [15:0] vec_wide = {13'h0000, source};

  // gpi 0-3 are sources 0-3, legacy a-d are 4-7
  assign found  = |pending;
  assign source = first_set(pending);                   // [RULE_08]
  // upper bits pass from the programmed data untouched
  assign data   = (payload & keep) | (vec_wide & ~keep); // [RULE_07] [RULE_09]

endmodule

// >>> rtl/msigen_top.sv
// message interrupt generator: ahb-lite registers, source capture
// and the sender of posted interrupt writes
// assumes one ahb-lite master, the upstream port on CLOCK, and
// interrupt source pins asynchronous to CLOCK
//
// Operation
// [RULE_01] low address bits 31:2 are software-set, word target of writes
// [RULE_02] write address bits 1:0 are zero; low register bits 1:0 read 0
// [RULE_03] upper address register is fully writable, resets to zero
// [RULE_04] nonzero upper register gives a 64-bit write address
// [RULE_05] zero upper register gives a 32-bit address from low register
// [RULE_06] 16-bit payload, resets zero, sent per message; 31:16 read 0
// [RULE_07] only low payload bits allowed by the vector count change
// [RULE_08] eight vectors: gpi 0-3 then legacy a-d, low 3 bits
// [RULE_09] unmodified upper bits come straight from programmed data
// [RULE_10] vector count code 0,1,2,3 means 1,2,4,8; 4-7 reserved
// [RULE_11] four vectors: low two bits carry vector number modulo four
// [RULE_12] two vectors: only bit 0 changes, odd vectors send one
// [RULE_13] single vector: payload sent unchanged for every source
// [RULE_14] no write while disabled; one write per source event; an edge on a source still pending gets no write of its own and is flagged lost
//
// The AHB-Lite slave port was left to the implementer.
`timescale 1ns/10ps
`include "msigen_defines.svh"

module msigen_top (
  input  wire logic                 CLOCK,        // core clock
  input  wire logic                 SYS_RST,      // sync reset
  input  wire logic                 HSEL,         // slave select
  input  wire logic [31:0]          HADDR,        // byte address
  input  wire logic [1:0]           HTRANS,       // transfer type
  input  wire logic                 HWRITE,       // write phase
  input  wire logic [2:0]           HSIZE,        // word only
  input  wire logic [31:0]          HWDATA,       // write data
  input  wire logic                 HREADY,       // bus ready
  output logic      [31:0]          HRDATA,       // read data
  output logic                      HREADYOUT,    // slave ready
  output logic                      HRESP,        // always okay
  input  wire logic [3:0]           GPI_IN,       // general inputs
  input  wire logic [3:0]           LEGACY_INT_N, // lines a-d
  output msigen_pkg::msigen_msg_t   MSG,          // write to send
  output logic                      MSG_VALID,    // write offered
  input  wire logic                 MSG_READY,    // write taken
  output logic                      IRQ           // local interrupt
);

  // bus phase tracking
  msigen_pkg::msigen_phase_t dphase;
  msigen_pkg::msigen_phase_t next_dphase;

  // software state
  logic        ctrl_enable;
  logic [2:0]  vcount;
  logic [29:0] addr_lo;
  logic [31:0] addr_hi;
  logic [15:0] payload;
  logic [1:0]  irq_status;
  logic [1:0]  irq_mask;
  logic [7:0]  sent_count;

  // source capture
  logic [7:0]  src_meta;
  logic [7:0]  src_sync;
  logic [7:0]  src_prev;
  logic [7:0]  pending;

  // sender
  msigen_pkg::msigen_state_t state;
  msigen_pkg::msigen_state_t next_state;
  logic        sel_found;
  logic [2:0]  sel_source;
  logic [15:0] sel_data;
  logic [31:0] read_word;

  // address phase is taken on select, an active htrans and a ready bus; size is
  // not checked since the master only issues whole words
  wire addr_take = HSEL && HTRANS[1] && HREADY;
  assign next_dphase = '{addr_take, HWRITE, HADDR[7:0]};

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      dphase <= '0;
    end else if (HREADY) begin
      dphase <= next_dphase;
    end
  end

  // write strobes, applied in the data phase when hwdata stands
  wire wr_any     = dphase.valid && dphase.write && HREADY;
  wire wr_control = wr_any && (dphase.addr == `MSIGEN_OFS_CONTROL);
  wire wr_addr_lo = wr_any && (dphase.addr == `MSIGEN_OFS_ADDR_LO);
  wire wr_addr_hi = wr_any && (dphase.addr == `MSIGEN_OFS_ADDR_HI);
  wire wr_payload = wr_any && (dphase.addr == `MSIGEN_OFS_PAYLOAD);
  wire wr_status  = wr_any && (dphase.addr == `MSIGEN_OFS_IRQ_STATUS);
  wire wr_mask    = wr_any && (dphase.addr == `MSIGEN_OFS_IRQ_MASK);

  // reads stall one cycle so the word is sampled after any write
  // in flight; costs a wait state but avoids a forwarding path
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      HREADYOUT <= 1'b1;
    end else begin
      HREADYOUT <= !(addr_take && !HWRITE);
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      HRDATA <= `MSIGEN_RST_WORD;
    end else if (!HREADYOUT) begin
      HRDATA <= read_word;
    end
  end

  // error responses are never given
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      HRESP <= 1'b0;
    end else begin
      HRESP <= 1'b0;
    end
  end

  // read words; unmapped offsets read as zero
  wire [31:0] ctrl_word = {9'h000, vcount, 3'h0, ctrl_enable, 16'h0000};
  wire [31:0] lo_word   = {addr_lo, 2'b00};                // [RULE_02]
  wire [31:0] pay_word  = {16'h0000, payload};             // [RULE_06]
  wire [31:0] pend_word = {24'h00_0000, pending};
  wire [31:0] stat_word = {30'h0000_0000, irq_status};
  wire [31:0] mask_word = {30'h0000_0000, irq_mask};
  wire [31:0] last_word = {13'h0000, MSG.vector, 8'h00, sent_count};

  assign read_word =
    (dphase.addr == `MSIGEN_OFS_CONTROL)    ? ctrl_word :
    (dphase.addr == `MSIGEN_OFS_ADDR_LO)    ? lo_word   :
    (dphase.addr == `MSIGEN_OFS_ADDR_HI)    ? addr_hi   :
    (dphase.addr == `MSIGEN_OFS_PAYLOAD)    ? pay_word  :
    (dphase.addr == `MSIGEN_OFS_PENDING)    ? pend_word :
    (dphase.addr == `MSIGEN_OFS_IRQ_STATUS) ? stat_word :
    (dphase.addr == `MSIGEN_OFS_IRQ_MASK)   ? mask_word :
    (dphase.addr == `MSIGEN_OFS_LAST_MSG)   ? last_word :
    `MSIGEN_RST_WORD;

  // control: enable and granted vector count, stored as written
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      ctrl_enable <= 1'b0;
      vcount      <= `MSIGEN_RST_VCOUNT;
    end else if (wr_control) begin
      ctrl_enable <= HWDATA[`MSIGEN_ENABLE_BIT];
      vcount      <= HWDATA[`MSIGEN_VCOUNT_MSB:`MSIGEN_VCOUNT_LSB]; // [RULE_10]
    end
  end

  // message target, low word bits 31:2 only
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      addr_lo <= 30'h0000_0000;
    end else if (wr_addr_lo) begin
      addr_lo <= HWDATA[31:2]; // [RULE_01] [RULE_02]
    end
  end

  // upper target word, every bit writable
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      addr_hi <= `MSIGEN_RST_WORD;
    end else if (wr_addr_hi) begin
      addr_hi <= HWDATA; // [RULE_03]
    end
  end

  // programmed message data, upper half of the word dropped
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      payload <= `MSIGEN_RST_PAYLOAD;
    end else if (wr_payload) begin
      payload <= HWDATA[15:0]; // [RULE_06]
    end
  end

  // two flops per pin before anything looks at the sources;
  // legacy lines are active low and are turned around first
  wire [7:0] src_raw = {~LEGACY_INT_N, GPI_IN};

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      src_meta <= 8'h00;
      src_sync <= 8'h00;
      src_prev <= 8'h00;
    end else begin
      src_meta <= src_raw;
      src_sync <= src_meta;
      src_prev <= src_sync;
    end
  end

  // an event is the assertion edge of a synchronised source
  wire [7:0] src_edge = src_sync & ~src_prev;

  // sender handshake terms
  wire launch = (state == msigen_pkg::MSIGEN_IDLE) && ctrl_enable
                && sel_found;                              // [RULE_14]
  wire done   = (state == msigen_pkg::MSIGEN_SEND) && MSG_READY;

  // the bit of the source being launched this cycle
  wire [7:0] pend_clear = launch ? (8'h01 << sel_source) : 8'h00;

  // events are only queued while enabled; an edge on a bit being
  // cleared keeps the bit, so that edge still gets its own write
  wire [7:0] pend_set = ctrl_enable ? src_edge : 8'h00;    // [RULE_14]
  wire [7:0] next_pending = (pending & ~pend_clear) | pend_set;

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      pending <= 8'h00;
    end else begin
      pending <= next_pending;
    end
  end

  // source choice and payload shaping
  msigen_vector_sel u_vector_sel (
    .pending (pending),
    .vcount  (vcount),
    .payload (payload),
    .found   (sel_found),
    .source  (sel_source),
    .data    (sel_data)
  );

  // an edge is lost when disabled or when its source still waits
  wire [7:0] lost_bits = src_edge & (ctrl_enable ?
                         (pending & ~pend_clear) : 8'hff);

  // address of the next write; the wide flag tells the upstream
  // port which header format to use
  wire        use_wide = (addr_hi != `MSIGEN_RST_WORD);     // [RULE_04]
  wire [63:0] tgt_wide = {addr_hi, addr_lo, 2'b00};         // [RULE_04]
  wire [63:0] tgt_narrow = {32'h0000_0000, addr_lo, 2'b00}; // [RULE_05]
  wire [63:0] tgt_addr = use_wide ? tgt_wide : tgt_narrow;  // [RULE_02]

  // sender state machine
  always_comb begin
    next_state = state;
    unique case (state)
      msigen_pkg::MSIGEN_IDLE: begin
        if (launch) begin
          next_state = msigen_pkg::MSIGEN_SEND;
        end
      end
      msigen_pkg::MSIGEN_SEND: begin
        if (done) begin
          next_state = msigen_pkg::MSIGEN_IDLE;
        end
      end
      default: begin
        next_state = msigen_pkg::MSIGEN_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      state <= msigen_pkg::MSIGEN_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // an offered write is never withdrawn, even if software
  // disables in the meantime; a half-offered write would confuse
  // the upstream port
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      MSG_VALID <= 1'b0;
    end else if (launch) begin
      MSG_VALID <= 1'b1; // [RULE_14]
    end else if (done) begin
      MSG_VALID <= 1'b0;
    end
  end

  // the write is frozen at launch so later register writes cannot
  // tear a message that is waiting for the upstream port
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      MSG <= '0;
    end else if (launch) begin
      MSG.addr   <= tgt_addr;   // [RULE_01] [RULE_04] [RULE_05]
      MSG.wide64 <= use_wide;   // [RULE_04]
      MSG.data   <= sel_data;   // [RULE_06] [RULE_07]
      MSG.vector <= sel_source; // [RULE_08]
    end
  end

  // count of writes taken upstream, wraps at 256
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      sent_count <= 8'h00;
    end else if (done) begin
      sent_count <= sent_count + 8'h01;
    end
  end

  // sticky status, write one to clear; a new event wins
  wire [1:0] irq_event = {|lost_bits, done};
  wire [1:0] irq_clear = wr_status ? HWDATA[1:0] : 2'b00;
  wire [1:0] next_irq_status = (irq_status & ~irq_clear) | irq_event;

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      irq_status <= 2'b00;
    end else begin
      irq_status <= next_irq_status;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      irq_mask <= 2'b00;
    end else if (wr_mask) begin
      irq_mask <= HWDATA[1:0];
    end
  end

  // interrupt follows the masked status in the same cycle
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |(next_irq_status & irq_mask);
    end
  end

endmodule

// >>> test/msigen_monitor.sv
// assertions on the ports of the message interrupt generator
// assumes it is bound to msigen_top and sees one clock domain
`timescale 1ns/10ps

module msigen_monitor (
  input wire logic                    CLOCK,     // core clock
  input wire logic                    SYS_RST,   // sync reset
  input wire logic                    HSEL,      // select
  input wire logic [31:0]             HADDR,     // address
  input wire logic [1:0]              HTRANS,    // transfer
  input wire logic                    HWRITE,    // write
  input wire logic                    HREADY,    // bus ready
  input wire logic [31:0]             HRDATA,    // read data
  input wire logic                    HREADYOUT, // slave ready
  input wire logic                    HRESP,     // response
  input wire msigen_pkg::msigen_msg_t MSG,       // message
  input wire logic                    MSG_VALID, // offered
  input wire logic                    MSG_READY  // taken
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);

  // a transfer is taken on select, active htrans and ready
  wire take = HSEL && HTRANS[1] && HREADY;
  wire rd   = take && !HWRITE;

  a_read_wait:
    assert property (rd |=> !HREADYOUT ##1 HREADYOUT)
    else $error("read wait state wrong");
  a_write_nowait:
    assert property (take && HWRITE |=> HREADYOUT)
    else $error("write was stalled");
  a_resp_okay:
    assert property (HRESP == 1'b0)
    else $error("response not okay");
  a_low_reads_zero:
    assert property (rd && HADDR[7:0] == 8'h84 |=> ##1 HRDATA[1:0] == 2'h0)
    else $error("low address bits 1:0 read nonzero");
  a_payload_upper_zero:
    assert property (rd && HADDR[7:0] == 8'h8c |=> ##1 HRDATA[31:16] == 0)
    else $error("payload bits 31:16 read nonzero");
  a_msg_addr_aligned:
    assert property (MSG_VALID |-> MSG.addr[1:0] == 2'h0)
    else $error("message address not word aligned");
  a_wide_flag:
    assert property (MSG_VALID |-> MSG.wide64 == (MSG.addr[63:32] != 0))
    else $error("address width flag wrong");
  a_msg_holds:
    assert property (MSG_VALID && !MSG_READY |=> MSG_VALID && $stable(MSG))
    else $error("offered message changed or withdrawn");
  a_gap_after_take:
    assert property (MSG_VALID && MSG_READY |=> !MSG_VALID)
    else $error("message offered again without a gap");
endmodule

bind msigen_top msigen_monitor msigen_monitor_inst (
  .CLOCK(CLOCK), .SYS_RST(SYS_RST), .HSEL(HSEL), .HADDR(HADDR),
  .HTRANS(HTRANS), .HWRITE(HWRITE), .HREADY(HREADY), .HRDATA(HRDATA),
  .HREADYOUT(HREADYOUT), .HRESP(HRESP), .MSG(MSG),
  .MSG_VALID(MSG_VALID), .MSG_READY(MSG_READY));

// >>> test/msigen_upstream_model.sv
// upstream port that takes posted interrupt writes
// assumes the offer and the accept share the core clock
`timescale 1ns/10ps

module msigen_upstream_model (
  input  wire logic clk,   // core clock
  input  wire logic rst,   // sync reset
  input  wire logic valid, // write offered
  output logic      ready  // write taken
);
  // random accept: sometimes at once, often after stalls, so the
  // sender must hold its offer over several cycles
  always_ff @(posedge clk) begin
    if (rst) begin
      ready <= 1'b0;
    end else begin
      ready <= ($urandom_range(0, 3) == 0);
    end
  end
endmodule

// >>> test/tb.sv
// self-checking bench of the message interrupt generator
// assumes the design, its monitor and the upstream model
`timescale 1ns/10ps

module tb;
  logic                    clock = 1'b0;   // core clock
  logic                    sys_rst = 1'b1; // sync reset
  logic                    hsel = 1'b0;    // bus select
  logic [31:0]             haddr = 32'h0;  // bus address
  logic [1:0]              htrans = 2'h0;  // transfer type
  logic                    hwrite = 1'b0;  // write phase
  logic [31:0]             hwdata = 32'h0; // write data
  logic [3:0]              gpi = 4'h0;     // general inputs
  logic [3:0]              leg_n = 4'hf;   // legacy lines
  logic [31:0]             hrdata;
  logic                    hreadyout;
  logic                    hresp;
  logic                    irq;
  logic                    msg_valid;
  logic                    msg_ready;
  msigen_pkg::msigen_msg_t msg;
  msigen_pkg::msigen_msg_t exp_q[$];       // expected messages
  int                      fails = 0;
  int                      checks_done = 0;
  logic [31:0]             rd, lo, hi;
  logic [15:0]             pay, keep;

  always #2.5 clock = ~clock;

  msigen_top msigen_top_inst (.CLOCK(clock), .SYS_RST(sys_rst),
    .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
    .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
    .HREADYOUT(hreadyout), .HRESP(hresp), .GPI_IN(gpi),
    .LEGACY_INT_N(leg_n), .MSG(msg), .MSG_VALID(msg_valid),
    .MSG_READY(msg_ready), .IRQ(irq));
  msigen_upstream_model msigen_upstream_model_inst (.clk(clock),
    .rst(sys_rst), .valid(msg_valid), .ready(msg_ready));

  task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp_msg(input logic [83:0] got, input logic [83:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one single word transfer; address held until ready, data after
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clock);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge clock); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clock); while (hreadyout !== 1'b1);
    rd = hrdata;
    hsel <= 1'b0;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    cmp32(rd, exp);
  endtask

  // raise the sources in set together; notes what should leave
  task automatic fire(input logic [7:0] set, input logic push);
    for (int n = 0; n < 8; n++)
      if (set[n] && push)
        exp_q.push_back({hi, lo[31:2], 2'h0, hi != 0,
                         (pay & keep) | (16'(n) & ~keep), 3'(n)});
    @(posedge clock);
    gpi <= set[3:0];
    leg_n <= ~set[7:4];
    repeat (4) @(posedge clock);
    gpi <= 4'h0;
    leg_n <= 4'hf;
    for (int k = 0; k < 400 && exp_q.size() != 0; k++) @(posedge clock);
    repeat (8) @(posedge clock);
  endtask

  // status read, irq high, w1c clear, irq low again
  task automatic clear_irq(input logic [31:0] bits);
    rdchk(8'h98, bits);
    cmp32({31'h0, irq}, 32'h1);
    bus(1'b1, 8'h98, bits);
    repeat (2) @(posedge clock);
    cmp32({31'h0, irq}, 32'h0);
  endtask

  // each accepted write takes the oldest note off the queue
  always @(posedge clock)
    if (msg_valid === 1'b1 && msg_ready === 1'b1) begin
      if (exp_q.size() == 0) cmp_msg(msg, ~msg);
      else cmp_msg(msg, exp_q.pop_front());
    end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // cuts a hang short
  initial begin
    repeat (40000) @(posedge clock);
    fails++;
    report_and_stop();
  end

  initial begin
    rd = $urandom(81192);
    repeat (12) @(posedge clock);
    sys_rst <= 1'b0;
    rdchk(8'h84, 32'h0);
    rdchk(8'h88, 32'h0);
    rdchk(8'h8c, 32'h0);
    rdchk(8'h40, 32'h0);
    bus(1'b1, 8'h84, 32'hffff_ffff);
    rdchk(8'h84, 32'hffff_fffc);
    bus(1'b1, 8'h8c, 32'hffff_ffff);
    rdchk(8'h8c, 32'h0000_ffff);
    hi = $urandom();
    bus(1'b1, 8'h88, hi);
    rdchk(8'h88, hi);
    // disabled: the event is dropped and flagged lost
    bus(1'b1, 8'h9c, 32'h3);
    rdchk(8'h9c, 32'h3);
    bus(1'b1, 8'h80, 32'h0);
    fire(8'h10, 1'b0);
    clear_irq(32'h2);
    // both address widths, every count code and one reserved code
    for (int h = 0; h < 2; h++)
      for (int c = 0; c < 5; c++) begin
        hi = h ? ($urandom() | 32'h1) : 32'h0;
        lo = $urandom();
        pay = 16'($urandom());
        keep = 16'hffff << (c < 4 ? c : 0);
        bus(1'b1, 8'h88, hi);
        bus(1'b1, 8'h84, lo);
        bus(1'b1, 8'h8c, {16'h0, pay});
        bus(1'b1, 8'h80, (32'(c) << 20) | 32'h0001_0000);
        rdchk(8'h80, (32'(c) << 20) | 32'h0001_0000);
        for (int n = 0; n < 8; n++) fire(8'(1 << n), 1'b1);
        fire(8'h84, 1'b1);
      end
    clear_irq(32'h1);
    cmp32(32'(exp_q.size()), 32'h0);
    // nothing left queued; ten configurations of ten writes each,
    // the last one launched from source 7
    rdchk(8'h94, 32'h0);
    rdchk(8'ha0, 32'h0007_0064);
    report_and_stop();
  end
endmodule
